// ===== common/nvs_pkg.sv
// nvs_pkg: constants and types for the nonvolatile save/restore sequencer
package nvs_pkg;

  // ***********************************************
  // clock and unit conversion
  // ***********************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int NS_PER_US = 1000;
  localparam int NS_PER_MS = 1000000;

  // ***********************************************
  // documented times, in their own units
  // ***********************************************
  localparam int WRITE_GRACE_TIME_NS = 25;
  localparam int SAVE_DURATION_MS = 8;
  localparam int RESTORE_DURATION_US = 600;
  localparam int POWERUP_RESTORE_LOW_MS = 40;
  localparam int POWERUP_RESTORE_STD_MS = 20;
  localparam int SOFT_COMMAND_LATENCY_US = 500;
  localparam int SLEEP_ENTRY_LATENCY_MS = 8;
  localparam int WAKE_LATENCY_LOW_MS = 40;
  localparam int WAKE_LATENCY_STD_MS = 20;
  localparam int STANDBY_ENTRY_LATENCY_US = 100;
  localparam int RESUME_AFTER_SAVE_PIN_HIGH_US = 5;
  localparam int SAVE_REQUEST_PULSE_MIN_NS = 15;

  // longest time: round down, never below one cycle
  function automatic int cyc_floor(input int ns);
    return (ns / CLK_PERIOD_NS < 1) ? 1 : ns / CLK_PERIOD_NS;
  endfunction

  // ***********************************************
  // derived cycle counts
  // ***********************************************
  localparam int GRACE_CYC = cyc_floor(WRITE_GRACE_TIME_NS);
  localparam int SAVE_CYC = cyc_floor(SAVE_DURATION_MS * NS_PER_MS);
  localparam int RESTORE_CYC = cyc_floor(RESTORE_DURATION_US * NS_PER_US);
  localparam int PWRUP_LOW_CYC =
    cyc_floor(POWERUP_RESTORE_LOW_MS * NS_PER_MS);
  localparam int PWRUP_STD_CYC =
    cyc_floor(POWERUP_RESTORE_STD_MS * NS_PER_MS);
  localparam int SOFT_CMD_CYC =
    cyc_floor(SOFT_COMMAND_LATENCY_US * NS_PER_US);
  localparam int SLEEP_CYC = cyc_floor(SLEEP_ENTRY_LATENCY_MS * NS_PER_MS);
  localparam int WAKE_LOW_CYC = cyc_floor(WAKE_LATENCY_LOW_MS * NS_PER_MS);
  localparam int WAKE_STD_CYC = cyc_floor(WAKE_LATENCY_STD_MS * NS_PER_MS);
  localparam int STANDBY_CYC =
    cyc_floor(STANDBY_ENTRY_LATENCY_US * NS_PER_US);
  localparam int RESUME_CYC =
    cyc_floor(RESUME_AFTER_SAVE_PIN_HIGH_US * NS_PER_US);

  // counter width, wide enough for the longest count
  localparam int CNT_W = 20;

  // ***********************************************
  // pin synchroniser layout and reset value
  // ***********************************************
  localparam int SYNC_W = 3;
  localparam int SYNC_SUPPLY_LOW = 0;
  localparam int SYNC_PIN_N = 1;
  localparam int SYNC_CS_N = 2;
  localparam logic [SYNC_W-1:0] SYNC_RST = 3'h7;

  // ***********************************************
  // sequencer states
  // ***********************************************
  typedef enum logic [9:0] {
    ST_WAIT_SUPPLY = 10'h001,
    ST_PWRUP = 10'h002,
    ST_READY = 10'h004,
    ST_GRACE = 10'h008,
    ST_SAVE = 10'h010,
    ST_RESTORE = 10'h020,
    ST_PIN_HOLD = 10'h040,
    ST_SLEEP_ENTRY = 10'h080,
    ST_SLEEP = 10'h100,
    ST_WAKE = 10'h200
  } nvs_state_e;

endpackage

// ===== hdl/nvs_timer.sv
// nvs_timer: loadable down counter that flags the last cycle of a delay
`timescale 1ns/10ps
module nvs_timer #(
  parameter int CNT_W = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic [CNT_W-1:0] startValue,
  // status
  output logic expired,
  output logic running
);

  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= startValue;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign expired = (cnt_q == CNT_W'(1));
  assign running = (cnt_q != '0);

endmodule // nvs_timer

// ===== hdl/nvs_sequencer.sv
// nvs_sequencer: save/restore, sleep and standby sequencer of the array
//
// Notes on behaviour
// - skip auto or pin save when array clean
// - accept writes one grace cycle, then block
// - ignore array access while busy or supply low, except writes in the grace cycle
// - block access until save or restore done
// - power-up restore within variant-dependent time
// - soft commands acted on promptly, supply up
// - sleep reached within sleep entry latency
// - ready again within wake latency
// - standby within latency after chip select high
// - resume soon after save pin high
// - array disabled while pin held low
`timescale 1ns/10ps
module nvs_sequencer
  import nvs_pkg::*;
#(
  parameter int SAVE_CYCLES = SAVE_CYC,
  parameter int RESTORE_CYCLES = RESTORE_CYC,
  parameter int PWRUP_LOW_CYCLES = PWRUP_LOW_CYC,
  parameter int PWRUP_STD_CYCLES = PWRUP_STD_CYC,
  parameter int SLEEP_CYCLES = SLEEP_CYC,
  parameter int WAKE_LOW_CYCLES = WAKE_LOW_CYC,
  parameter int WAKE_STD_CYCLES = WAKE_STD_CYC,
  parameter int SOFT_CMD_CYCLES = SOFT_CMD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous pins
  input wire logic supplyLow,
  input wire logic saveBusyIn_n,
  input wire logic chipSel_n,
  // commands from the serial decoder
  input wire logic softSaveReq,
  input wire logic softRestoreReq,
  input wire logic sleepReq,
  input wire logic wakeReq,
  input wire logic autoSaveEnable,
  input wire logic lowVoltVariant,
  input wire logic sramWrite,
  // array gating
  output logic readEnable_q,
  output logic writeEnable_q,
  // save/busy open-drain pin
  output logic saveBusyOut_q,
  output logic saveBusyOe_q,
  // status
  output logic opBusy_q,
  output logic sleeping_q,
  output logic standby_q
);

  // ***********************************************
  // pin synchronisers
  // ***********************************************
  logic [SYNC_W-1:0] syncA_q;
  logic [SYNC_W-1:0] syncB_q;
  logic csPrev_q;
  logic supplyLowS;
  logic pinLowS;
  logic csRise;

  always_ff @(posedge clk) begin
    if (rst) begin
      syncA_q <= SYNC_RST;
      syncB_q <= SYNC_RST;
      csPrev_q <= 1'b1;
    end else begin
      syncA_q <= {chipSel_n, saveBusyIn_n, supplyLow};
      syncB_q <= syncA_q;
      csPrev_q <= syncB_q[SYNC_CS_N];
    end
  end

  assign supplyLowS = syncB_q[SYNC_SUPPLY_LOW];
  assign pinLowS = !syncB_q[SYNC_PIN_N];
  assign csRise = syncB_q[SYNC_CS_N] && !csPrev_q;
  // ***********************************************
  // next state
  // ***********************************************
  nvs_state_e stateQ;
  nvs_state_e stateD;
  logic dirty_q;
  logic opStart;
  logic [CNT_W-1:0] opValue;
  logic opExpired;
  logic [CNT_W-1:0] pwrupCnt;
  logic [CNT_W-1:0] wakeCnt;

  assign pwrupCnt = lowVoltVariant ? CNT_W'(PWRUP_LOW_CYCLES)
                                   : CNT_W'(PWRUP_STD_CYCLES);
  assign wakeCnt = lowVoltVariant ? CNT_W'(WAKE_LOW_CYCLES)
                                  : CNT_W'(WAKE_STD_CYCLES);

  always_comb begin
    stateD = stateQ;
    opStart = 1'b0;
    opValue = '0;
    unique case (stateQ)
      ST_WAIT_SUPPLY: if (!supplyLowS) begin
        stateD = ST_PWRUP;
        opStart = 1'b1;
        opValue = pwrupCnt;
      end
      ST_PWRUP: if (opExpired) begin
        stateD = supplyLowS ? ST_WAIT_SUPPLY : ST_PIN_HOLD;
      end
      ST_READY: if (supplyLowS) begin
        // auto save only when enabled and the array changed
        stateD = (autoSaveEnable && dirty_q) ? ST_GRACE
                                             : ST_WAIT_SUPPLY;
      end else if (pinLowS) begin
        stateD = dirty_q ? ST_GRACE : ST_PIN_HOLD;
      end else if (softSaveReq) begin
        stateD = ST_SAVE;
        opStart = 1'b1;
        opValue = CNT_W'(SAVE_CYCLES);
      end else if (softRestoreReq) begin
        stateD = ST_RESTORE;
        opStart = 1'b1;
        opValue = CNT_W'(RESTORE_CYCLES);
      end else if (sleepReq) begin
        stateD = ST_SLEEP_ENTRY;
        opStart = 1'b1;
        opValue = CNT_W'(SLEEP_CYCLES);
      end
      ST_GRACE: begin
        stateD = ST_SAVE;
        opStart = 1'b1;
        opValue = CNT_W'(SAVE_CYCLES);
      end
      // pin hold afterwards lets our own drive drain out of the sync
      ST_SAVE, ST_RESTORE: if (opExpired) begin
        stateD = supplyLowS ? ST_WAIT_SUPPLY : ST_PIN_HOLD;
      end
      ST_PIN_HOLD: if (supplyLowS) begin
        stateD = ST_WAIT_SUPPLY;
      end else if (!pinLowS) begin
        stateD = ST_READY;
      end
      ST_SLEEP_ENTRY: if (opExpired) begin
        stateD = ST_SLEEP;
      end
      ST_SLEEP: if (wakeReq) begin
        stateD = ST_WAKE;
        opStart = 1'b1;
        opValue = wakeCnt;
      end
      ST_WAKE: if (opExpired) begin
        stateD = ST_READY;
      end
      default: stateD = ST_WAIT_SUPPLY;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      stateQ <= ST_WAIT_SUPPLY;
    end else begin
      stateQ <= stateD;
    end
  end
  nvs_timer #(.CNT_W(CNT_W)) opTimer (
    .clk(clk), .rst(rst), .start(opStart), .startValue(opValue),
    .expired(opExpired), .running()
  );
  // ***********************************************
  // written-since-last-operation flag
  // ***********************************************
  logic nvDone;
  assign nvDone = opExpired &&
    (stateQ == ST_SAVE || stateQ == ST_RESTORE || stateQ == ST_PWRUP);
  always_ff @(posedge clk) begin
    if (rst) begin
      dirty_q <= 1'b0;
    end else if (sramWrite && writeEnable_q) begin
      dirty_q <= 1'b1;
    end else if (nvDone) begin
      dirty_q <= 1'b0;
    end
  end
  // ***********************************************
  // array gating and pin drive
  // ***********************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      readEnable_q <= 1'b0;
      writeEnable_q <= 1'b0;
    end else begin
      readEnable_q <= (stateD == ST_READY) && !supplyLowS;
      writeEnable_q <= (stateD == ST_READY || stateD == ST_GRACE)
                       && (!supplyLowS || stateD == ST_GRACE);
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      saveBusyOut_q <= 1'b0;
      saveBusyOe_q <= 1'b0;
      opBusy_q <= 1'b0;
      sleeping_q <= 1'b0;
    end else begin
      saveBusyOut_q <= 1'b0;
      saveBusyOe_q <= stateD == ST_SAVE || stateD == ST_RESTORE
                      || stateD == ST_PWRUP;
      opBusy_q <= stateD != ST_READY;
      sleeping_q <= stateD == ST_SLEEP;
    end
  end
  // ***********************************************
  // standby entry after chip select release
  // ***********************************************
  logic sbExpired;
  // reload while busy so the count starts again on return to ready
  nvs_timer #(.CNT_W(CNT_W)) sbTimer (
    .clk(clk), .rst(rst),
    .start(csRise || (syncB_q[SYNC_CS_N] && stateQ != ST_READY)),
    .startValue(CNT_W'(STANDBY_CYC)), .expired(sbExpired), .running()
  );
  always_ff @(posedge clk) begin
    if (rst) begin
      standby_q <= 1'b0;
    end else if (!syncB_q[SYNC_CS_N] || stateQ != ST_READY) begin
      standby_q <= 1'b0;
    end else if (sbExpired) begin
      standby_q <= 1'b1;
    end
  end
  // ***********************************************
  // checks
  // ***********************************************
  logic [CNT_W-1:0] age_q;
  logic [CNT_W-1:0] csHighAge_q;
  always_ff @(posedge clk) begin
    if (rst || stateD != stateQ) begin
      age_q <= '0;
    end else if (age_q != '1) begin
      age_q <= age_q + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || !syncB_q[SYNC_CS_N] || stateQ != ST_READY) begin
      csHighAge_q <= '0;
    end else if (csHighAge_q != '1) begin
      csHighAge_q <= csHighAge_q + 1'b1;
    end
  end
  sequence sGraceThenSave;
    stateQ == ST_GRACE ##1 stateQ == ST_SAVE;
  endsequence
  a_skip_clean: assert property (@(posedge clk) disable iff (rst)
    (stateQ == ST_READY && !dirty_q && (pinLowS || supplyLowS))
    |=> stateQ != ST_GRACE)
    else $error("save started on clean array");
  a_grace_one: assert property (@(posedge clk) disable iff (rst)
    sGraceThenSave |-> !writeEnable_q)
    else $error("writes not blocked after grace");
  a_block_array: assert property (@(posedge clk) disable iff (rst)
    (stateQ == ST_SAVE || stateQ == ST_RESTORE || stateQ == ST_PWRUP)
    |-> !readEnable_q && !writeEnable_q)
    else $error("array open during operation");
  a_save_bound: assert property (@(posedge clk) disable iff (rst)
    (stateQ == ST_SAVE) |-> age_q < CNT_W'(SAVE_CYCLES))
    else $error("save too long");
  a_pwrup_bound: assert property (@(posedge clk) disable iff (rst)
    (stateQ == ST_PWRUP) |-> age_q < pwrupCnt)
    else $error("power-up restore too long");
  a_soft_act: assert property (@(posedge clk) disable iff (rst)
    (stateQ == ST_READY && !supplyLowS && !pinLowS && softSaveReq)
    |=> stateQ == ST_SAVE ##0 saveBusyOe_q)
    else $error("soft save not acted on");
  a_sleep_bound: assert property (@(posedge clk) disable iff (rst)
    (stateQ == ST_SLEEP_ENTRY) |-> age_q < CNT_W'(SLEEP_CYCLES))
    else $error("sleep entry too long");
  a_wake_bound: assert property (@(posedge clk) disable iff (rst)
    (stateQ == ST_WAKE) |-> age_q < wakeCnt)
    else $error("wake too long");
  a_standby_set: assert property (@(posedge clk) disable iff (rst)
    (csHighAge_q > CNT_W'(STANDBY_CYC + 2)) |-> standby_q)
    else $error("standby not entered");
  a_resume_fast: assert property (@(posedge clk) disable iff (rst)
    (stateQ == ST_PIN_HOLD && !pinLowS && !supplyLowS)
    |=> ##[0:1] readEnable_q)
    else $error("no resume after pin high");
  a_pin_hold: assert property (@(posedge clk) disable iff (rst)
    (stateQ == ST_READY && pinLowS) |=> !readEnable_q)
    else $error("array open while pin low");
  a_auto_start: assert property (@(posedge clk) disable iff (rst)
    (stateQ == ST_READY && supplyLowS && autoSaveEnable && dirty_q)
    |=> sGraceThenSave)
    else $error("auto save not started");
endmodule // nvs_sequencer

// ===== tb/nvs_host_model.sv
// host-side model: chip select and open-drain pull on the save pin
`timescale 1ns/10ps
module nvs_host_model (
  // clock
  input wire logic clk,
  // pins
  output logic pinPull,
  output logic chipSel_n
);
  initial begin
    pinPull = 1'h0;
    chipSel_n = 1'h0;
  end

  // pull the save pin low for n cycles, never under two
  task automatic holdPin(input int n);
    @(posedge clk);
    pinPull <= 1'h1;
    repeat (n < 2 ? 2 : n) @(posedge clk);
    pinPull <= 1'h0;
  endtask

  task automatic setCs(input logic v);
    @(posedge clk);
    chipSel_n <= v;
  endtask
endmodule // nvs_host_model

// ===== tb/tb.sv
// self-checking bench of the save/restore sequencer
`timescale 1ns/10ps
module tb;
  import nvs_pkg::*;
  // ***********************************************
  // shortened counts and signals
  // ***********************************************
  localparam int SAVE_N = 20;
  localparam int REST_N = 10;
  localparam int PUL_N = 30;
  localparam int PUS_N = 15;
  localparam int SLEEP_N = 12;
  localparam int WAKL_N = 30;
  localparam int WAKS_N = 15;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic supplyLow = 1'h0;
  logic softSaveReq = 1'h0;
  logic softRestoreReq = 1'h0;
  logic sleepReq = 1'h0;
  logic wakeReq = 1'h0;
  logic autoSaveEnable = 1'h1;
  logic lowVoltVariant = 1'h0;
  logic sramWrite = 1'h0;
  logic pinPull, chipSel_n, savePin;
  logic readEnable_q, writeEnable_q, saveBusyOut_q, saveBusyOe_q;
  logic opBusy_q, sleeping_q, standby_q;
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 64559;
  int dirty = 0;
  int n, w, i, hold;

  always #50 clk = ~clk;
  // open-drain pin with pull-up
  assign savePin = ~((saveBusyOe_q & ~saveBusyOut_q) | pinPull);

  nvs_host_model u_host (.clk(clk), .pinPull(pinPull),
    .chipSel_n(chipSel_n));

  nvs_sequencer #(.SAVE_CYCLES(SAVE_N), .RESTORE_CYCLES(REST_N),
    .PWRUP_LOW_CYCLES(PUL_N), .PWRUP_STD_CYCLES(PUS_N),
    .SLEEP_CYCLES(SLEEP_N), .WAKE_LOW_CYCLES(WAKL_N),
    .WAKE_STD_CYCLES(WAKS_N)) u_nvs_sequencer (
    .clk(clk), .rst(rst), .supplyLow(supplyLow),
    .saveBusyIn_n(savePin), .chipSel_n(chipSel_n),
    .softSaveReq(softSaveReq), .softRestoreReq(softRestoreReq),
    .sleepReq(sleepReq), .wakeReq(wakeReq),
    .autoSaveEnable(autoSaveEnable), .lowVoltVariant(lowVoltVariant),
    .sramWrite(sramWrite), .readEnable_q(readEnable_q),
    .writeEnable_q(writeEnable_q), .saveBusyOut_q(saveBusyOut_q),
    .saveBusyOe_q(saveBusyOe_q), .opBusy_q(opBusy_q),
    .sleeping_q(sleeping_q), .standby_q(standby_q));

  // ***********************************************
  // helpers
  // ***********************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cyc();
    @(posedge clk);
    #1;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return readEnable_q;
      3: return sleeping_q;
      default: return standby_q;
    endcase
  endfunction

  task automatic waitOn(input int k, input logic v, input int lim,
    output int t);
    t = 0;
    while (sig(k) !== v && t < lim) begin
      cyc();
      t++;
    end
    if (sig(k) !== v) begin
      error_cnt++;
      $display("unexpected at %0t: wait %0h limit %0h", $time, k, lim);
      summarize();
    end
  endtask

  task automatic cmd(input int k);
    @(posedge clk);
    case (k)
      0: softSaveReq <= 1'h1;
      1: softRestoreReq <= 1'h1;
      2: sleepReq <= 1'h1;
      3: wakeReq <= 1'h1;
      default: sramWrite <= 1'h1;
    endcase
    #1;
    if (k == 4 && writeEnable_q === 1'h1) begin
      dirty = 1;
    end
    @(posedge clk);
    softSaveReq <= 1'h0;
    softRestoreReq <= 1'h0;
    sleepReq <= 1'h0;
    wakeReq <= 1'h0;
    sramWrite <= 1'h0;
    #1;
  endtask

  // wait up to lim for the pin drive, then measure how long it stands
  task automatic oeLen(input int lim, output int len, output int t);
    t = 0;
    len = 0;
    while (saveBusyOe_q !== 1'h1 && t < lim) begin
      cyc();
      t++;
    end
    while (saveBusyOe_q === 1'h1 && len < 1000) begin
      chk(readEnable_q, 1'h0);
      chk(opBusy_q, 1'h1);
      chk(saveBusyOut_q, 1'h0);
      cyc();
      len++;
    end
  endtask

  task automatic randVariant();
    @(posedge clk);
    lowVoltVariant <= 1'($random(seed));
  endtask

  // ***********************************************
  // scenarios
  // ***********************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    oeLen(12, n, w);
    chk(n > 0 && n <= PUS_N, 1'h1);
    waitOn(0, 1'h1, 20, n);
    $display("test power-up done");
    for (i = 0; i < 2; i++) begin
      cmd(i);
      oeLen(4, n, w);
      chk(w <= 2, 1'h1);
      chk(n, i ? REST_N : SAVE_N);
      dirty = 0;
      waitOn(0, 1'h1, 20, n);
      chk(writeEnable_q, 1'h1);
      chk(opBusy_q, 1'h0);
    end
    $display("test soft save and restore done");
    for (i = 0; i < 2; i++) begin
      if (i == 0) begin
        cmd(4);
      end
      hold = 14 + ($random(seed) & 3);
      fork
        u_host.holdPin(hold);
        begin
          waitOn(0, 1'h0, 6, n);
          if (dirty) begin
            chk(writeEnable_q, 1'h1);
          end
          oeLen(8, n, w);
          chk(n, dirty ? SAVE_N : 0);
          chk(readEnable_q, 1'h0);
        end
      join
      dirty = 0;
      waitOn(0, 1'h1, 50, n);
    end
    $display("test pin save done");
    for (i = 0; i < 3; i++) begin
      if (i != 1) begin
        cmd(4);
      end
      @(posedge clk);
      supplyLow <= 1'h1;
      autoSaveEnable <= (i != 2);
      oeLen(10, n, w);
      chk(n, (dirty && i != 2) ? SAVE_N : 0);
      dirty = 0;
      repeat (4) cyc();
      chk({readEnable_q, writeEnable_q}, 2'h0);
      randVariant();
      @(posedge clk);
      supplyLow <= 1'h0;
      autoSaveEnable <= 1'h1;
      oeLen(12, n, w);
      chk(n > 0 && n <= (lowVoltVariant ? PUL_N : PUS_N), 1'h1);
      waitOn(0, 1'h1, 20, n);
    end
    $display("test power loss done");
    cmd(2);
    waitOn(3, 1'h1, 20, n);
    chk(n <= SLEEP_N + 1, 1'h1);
    randVariant();
    cmd(3);
    waitOn(0, 1'h1, 40, n);
    chk(n <= (lowVoltVariant ? WAKL_N : WAKS_N) + 1, 1'h1);
    chk(sleeping_q, 1'h0);
    $display("test sleep done");
    u_host.setCs(1'h1);
    waitOn(4, 1'h1, 1100, n);
    chk(n <= STANDBY_CYC + 4, 1'h1);
    u_host.setCs(1'h0);
    waitOn(4, 1'h0, 6, n);
    $display("test standby done");
    summarize();
  end
endmodule // tb
